// ### radcfg_host.sv
`timescale 1ns/1ns
`default_nettype none

module radcfg_host (
  // Clock
  input wire logic clk,
  // Resolved data line
  input wire logic line,
  // Serial pins
  output logic select,
  output logic sclk,
  output logic sdata,
  output logic sdata_oe
);
  //////////////////////////////////////////////////////////////////////////////
  // Idle: clock low, host owns the data line
  initial begin
    select = 1'b0;
    sclk = 1'b0;
    sdata = 1'b0;
    sdata_oe = 1'b1;
  end

  // One transfer; sel low replays the same wiggles unselected
  task automatic xfer(input logic sel, input logic rw, input logic [1:0] addr,
                      input int nbits, input logic [23:0] wd, output logic [23:0] rd);
    logic [26:0] bits;
    bits = {rw, addr, wd << (24 - nbits)};
    rd = 24'h00_0000;
    @(posedge clk);
    select <= sel;
    repeat (6) @(posedge clk);
    for (int i = 0; i < nbits + 3; i++) begin
      sdata_oe <= !(rw && i >= 3); // Release for read data
      sdata <= bits[26 - i];
      repeat (2) @(posedge clk);
      sclk <= 1'b1;
      repeat (5) @(posedge clk);
      if (i >= 3) begin
        rd = {rd[22:0], line}; // Data bits only, at our falling edge
      end
      sclk <= 1'b0;
      @(posedge clk);
    end
    select <= 1'b0;
    // Take the line back only once the port has let go
    repeat (8) @(posedge clk);
    sdata_oe <= 1'b1;
  endtask
endmodule

`default_nettype wire

// ### radcfg_pkg.sv
package radcfg_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  // Over-the-air bit time used by the recovery logic
  localparam int BIT_TIME_NS = 10000;
  localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] BIT_LAST = 7'(BIT_CYCLES - 1);
  localparam logic [6:0] BIT_MID = 7'(BIT_CYCLES / 2);

  //////////////////////////////////////////////////////////////////////////////
  // Packet start symbol, oldest bit in the MSB
  localparam logic [7:0] START_SYMBOL = 8'he3;

  //////////////////////////////////////////////////////////////////////////////
  // Control register map and fields
  localparam logic [1:0] ADDR_FIRST = 2'h0;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam int RECOV_EN_BIT = 0;
  localparam logic [2:0] DATA_LAST_BIT = 3'h7;

  typedef struct packed {
    logic [7:0] reg2;
    logic [7:0] reg1;
    logic [7:0] reg0;
  } radcfg_bytes_s;

  localparam radcfg_bytes_s REGS_RESET = '{reg2: 8'h00, reg1: 8'h00, reg0: 8'h00};
  localparam logic ACTIVE_RESET = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Serial pins as they arrive
  typedef struct packed {
    logic select;
    logic sclk;
    logic sdata;
  } radcfg_pins_s;

  // Serial transfer phases
  typedef enum logic [1:0] {
    PH_RW,
    PH_A1,
    PH_A0,
    PH_DATA
  } radcfg_phase_e;

  // Byte selection by register address; unmapped address reads zero
  function automatic logic [7:0] pick_byte(radcfg_bytes_s bytes, logic [1:0] a);
    case (a)
      2'h0: pick_byte = bytes.reg0;
      2'h1: pick_byte = bytes.reg1;
      2'h2: pick_byte = bytes.reg2;
      default: pick_byte = 8'h00;
    endcase
  endfunction

endpackage

// ### radcfg_port.sv
// How it works
// R1: Recovery disabled keeps the recovered bit clock low.
// R2: Recovery enabled: clock stays low until a start symbol is seen.
// R3: Each recovered bit appears on data out at the clock rising edge.
// R4: Once started, the bit clock runs until register 0 bit 0 is cleared.
// R5: Host clears the recovery enable after a complete packet.
// R6: With select high the data line shifts bytes in or out.
// R7: Every eighth data bit of a write transfer writes the assembled byte to the addressed register.
// R8: Write bits are captured on the serial clock rising edge.
// R9: Read bits are driven at the serial clock rising edge.
// R10: Select low makes the port ignore serial clock and data.
// R11: Host raises select before any serial clock pulses.
// R12: Select low at power-up leaves the device in legacy pin mode.
// R13: First select high switches permanently to serial control mode.
// R14: Select rising wakes the device into active mode.
// R15: Transfer is read/write flag, two address bits, eight data bits MSB first.
// R16: Address increments after each byte, wrapping from two back to zero.
// R17: Data out switches from raw slicer to recovered bits at start symbol.
// R18: Data line is driven only in the data phase of a read.
// R19: Select falling resets bit counting and drops a partial byte.
`timescale 1ns/1ns
`default_nettype none

module radcfg_port (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial configuration pins
  input wire logic config_select,
  input wire logic config_serial_clock,
  input wire logic config_serial_data_in,
  output logic config_serial_data_out,
  output logic config_serial_data_oe,
  // Receiver
  input wire logic slicer_data,
  output logic receive_data_out,
  output logic recovered_bit_clock,
  // Mode and power
  input wire logic sleep_request,
  output logic serial_control_mode,
  output logic active_mode,
  // Control register contents
  output radcfg_pkg::radcfg_bytes_s config_regs
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage one feeds stage two only
  radcfg_pkg::radcfg_pins_s pins_meta;
  radcfg_pkg::radcfg_pins_s pins_sync;
  logic sclk_prev;
  logic sel_prev;
  logic slicer_meta;
  logic slicer_sync;
  logic slicer_prev;

  always_ff @(posedge clk) begin
    pins_meta <= '{select: config_select, sclk: config_serial_clock,
                   sdata: config_serial_data_in};
    pins_sync <= reset ? '0 : pins_meta; // Idle levels, so no unknown or edge follows reset
    sclk_prev <= reset ? 1'b0 : pins_sync.sclk;
    sel_prev <= reset ? 1'b0 : pins_sync.select;
    slicer_meta <= reset ? 1'b0 : slicer_data;
    slicer_sync <= reset ? 1'b0 : slicer_meta;
    slicer_prev <= reset ? 1'b0 : slicer_sync;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge decode; a deselected port sees no clock at all
  wire port_live = pins_sync.select; // [R10] [R11]
  wire sclk_rise = pins_sync.sclk & ~sclk_prev;
  wire sel_rise = pins_sync.select & ~sel_prev;
  wire take = sclk_rise & port_live; // [R6] [R8]

  //////////////////////////////////////////////////////////////////////////////
  // Serial transfer state
  radcfg_pkg::radcfg_phase_e phase;
  logic rw_read;
  logic [1:0] addr;
  logic [2:0] bit_idx;
  logic [6:0] shift_in;
  logic [7:0] rd_data;

  wire in_data = phase == radcfg_pkg::PH_DATA;
  wire byte_done = take & in_data & (bit_idx == radcfg_pkg::DATA_LAST_BIT);
  wire [7:0] byte_in = {shift_in, pins_sync.sdata};
  wire wr_fire = byte_done & ~rw_read; // [R7]
  wire [1:0] next_addr = (addr >= radcfg_pkg::ADDR_LAST) ? radcfg_pkg::ADDR_FIRST :
                         2'(addr + 2'h1); // [R16]
  wire [2:0] rd_bit = radcfg_pkg::DATA_LAST_BIT - bit_idx; // MSB first
  wire drive_bit = take & in_data & rw_read;

  // Header then data bytes; dropping select abandons any partial byte
  always_ff @(posedge clk) begin
    if (reset || !port_live) begin // [R19]
      phase <= radcfg_pkg::PH_RW;
      bit_idx <= 3'h0;
      shift_in <= 7'h00;
    end else if (take) begin
      case (phase) // [R15]
        radcfg_pkg::PH_RW: begin
          phase <= radcfg_pkg::PH_A1;
        end
        radcfg_pkg::PH_A1: begin
          phase <= radcfg_pkg::PH_A0;
        end
        radcfg_pkg::PH_A0: begin
          phase <= radcfg_pkg::PH_DATA;
          bit_idx <= 3'h0;
        end
        radcfg_pkg::PH_DATA: begin
          shift_in <= byte_in[6:0]; // [R8]
          bit_idx <= 3'(bit_idx + 3'h1);
        end
        default: begin
          phase <= radcfg_pkg::PH_RW;
        end
      endcase
    end
  end

  // Direction flag and address; address steps after every byte
  always_ff @(posedge clk) begin
    if (reset) begin
      rw_read <= 1'b0;
      addr <= radcfg_pkg::ADDR_FIRST;
    end else if (take && phase == radcfg_pkg::PH_RW) begin
      rw_read <= pins_sync.sdata;
    end else if (take && phase == radcfg_pkg::PH_A1) begin
      addr <= {pins_sync.sdata, 1'b0};
    end else if (take && phase == radcfg_pkg::PH_A0) begin
      addr <= {addr[1], pins_sync.sdata};
    end else if (byte_done) begin
      addr <= next_addr; // [R16]
    end
  end

  // Read drive: the host turns the line around before data, so the
  // enable only rises at the first data-phase edge of a read
  always_ff @(posedge clk) begin
    if (reset || !port_live) begin
      config_serial_data_oe <= 1'b0; // [R18]
      config_serial_data_out <= 1'b0;
    end else if (drive_bit) begin
      config_serial_data_oe <= 1'b1; // [R9]
      config_serial_data_out <= rd_data[rd_bit];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register store
  radcfg_regs u_regs (
    .clk(clk),
    .reset(reset),
    .wr_en(wr_fire),
    .wr_addr(addr),
    .wr_data(byte_in),
    .rd_addr(addr),
    .rd_data(rd_data),
    .regs(config_regs)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Mode and power: power-up reset starts in legacy mode, never returns
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_control_mode <= 1'b0; // [R12]
      active_mode <= radcfg_pkg::ACTIVE_RESET;
    end else begin
      if (sel_rise) begin
        serial_control_mode <= 1'b1; // [R13]
      end
      if (sel_rise) begin
        active_mode <= 1'b1; // [R14] wake beats a same-cycle sleep
      end else if (sleep_request) begin
        active_mode <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit timing: a slicer edge re-centres the bit window, sample mid-bit
  wire recov_en = config_regs.reg0[radcfg_pkg::RECOV_EN_BIT];
  wire slicer_edge = slicer_sync ^ slicer_prev;
  logic [6:0] bit_cnt;
  logic [7:0] hunt;
  logic locked;

  wire sample = bit_cnt == radcfg_pkg::BIT_MID;
  wire bit_end = slicer_edge | (bit_cnt == radcfg_pkg::BIT_LAST);
  wire [7:0] next_hunt = {hunt[6:0], slicer_sync};
  wire start_seen = sample & (next_hunt == radcfg_pkg::START_SYMBOL);

  always_ff @(posedge clk) begin
    if (reset || bit_end) begin
      bit_cnt <= 7'h00;
    end else begin
      bit_cnt <= 7'(bit_cnt + 7'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hunt <= 8'h00;
    end else if (sample) begin
      hunt <= next_hunt;
    end
  end

  // Lock holds until software drops the enable; no end-of-packet logic
  always_ff @(posedge clk) begin
    if (reset || !recov_en) begin
      locked <= 1'b0; // [R4] [R5]
    end else if (start_seen) begin
      locked <= 1'b1; // [R2]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Recovered clock high from mid-bit to bit end; data changes as it rises
  always_ff @(posedge clk) begin
    if (reset || !recov_en || !locked) begin
      recovered_bit_clock <= 1'b0; // [R1] [R2]
    end else if (sample) begin
      recovered_bit_clock <= 1'b1; // [R3]
    end else if (bit_end) begin
      recovered_bit_clock <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      receive_data_out <= 1'b0;
    end else if (!locked || sample) begin
      receive_data_out <= slicer_sync; // [R3] [R17]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  chk_clk_disabled_low: assert property ( // [R1]
    !recov_en |=> !recovered_bit_clock)
    else $error("bit clock moved while recovery disabled");
  chk_clk_waits_start: assert property ( // [R2]
    !locked ##1 !locked |-> !recovered_bit_clock)
    else $error("bit clock pulsed before start symbol");
  chk_data_at_rise: assert property ( // [R3]
    $rose(recovered_bit_clock) |-> receive_data_out == $past(slicer_sync))
    else $error("recovered bit not presented at clock rise");
  chk_lock_holds: assert property ( // [R4]
    locked && recov_en |=> locked)
    else $error("bit clock stopped while enabled");
  chk_byte_lands: assert property ( // [R7] [R8]
    wr_fire && addr <= radcfg_pkg::ADDR_LAST |=> ##1
      radcfg_pkg::pick_byte(config_regs, $past(addr, 2)) == $past(byte_in, 2))
    else $error("written byte not stored at addressed register");
  chk_unmapped_drop: assert property ( // [R7]
    wr_fire && addr > radcfg_pkg::ADDR_LAST |=> ##1 config_regs == $past(config_regs, 2))
    else $error("write to unmapped address changed a register");
  chk_read_drive: assert property ( // [R9]
    drive_bit |=> config_serial_data_oe && config_serial_data_out == $past(rd_data[rd_bit]))
    else $error("read bit not driven at serial clock rise");
  chk_quiet_deselect: assert property ( // [R10] [R18]
    !port_live |=> !config_serial_data_oe && phase == radcfg_pkg::PH_RW)
    else $error("port active while deselected");
  chk_oe_only_read: assert property ( // [R18]
    !rw_read && !$past(rw_read) |-> !config_serial_data_oe)
    else $error("data line driven outside a read");
  chk_fresh_restart: assert property ( // [R19]
    $fell(pins_sync.select) |=> phase == radcfg_pkg::PH_RW && bit_idx == 3'h0)
    else $error("partial transfer survived select drop");
  chk_mode_sticks: assert property ( // [R12] [R13]
    sel_rise |=> serial_control_mode [*8])
    else $error("serial control mode not entered or lost");
  chk_wake_on_select: assert property ( // [R14]
    sel_rise |=> active_mode)
    else $error("select rise did not wake device");
  chk_header_order: assert property ( // [R15]
    take && phase == radcfg_pkg::PH_A0 |=> in_data && addr[0] == $past(pins_sync.sdata))
    else $error("address bit order wrong");
  chk_addr_wrap: assert property ( // [R16]
    byte_done && addr == radcfg_pkg::ADDR_LAST |=> addr == radcfg_pkg::ADDR_FIRST)
    else $error("address did not wrap to first register");
  chk_raw_pass: assert property ( // [R17]
    !locked |=> receive_data_out == $past(slicer_sync))
    else $error("raw slicer data not passed before lock");

  cov_write_byte: cover property (wr_fire);
  cov_read_byte: cover property (byte_done && rw_read);
  cov_start_lock: cover property (start_seen && recov_en);
  cov_wrap_multi: cover property (byte_done && addr == radcfg_pkg::ADDR_LAST ##[1:400] byte_done);

endmodule

`default_nettype wire

// ### radcfg_regs.sv
`timescale 1ns/1ns
`default_nettype none

module radcfg_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write port
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [1:0] rd_addr,
  output logic [7:0] rd_data,
  // Register contents
  output radcfg_pkg::radcfg_bytes_s regs
);

  logic [7:0] store [3];

  //////////////////////////////////////////////////////////////////////////////
  // One byte per register; an address past the last is dropped on write
  for (genvar i = 0; i < 3; i++) begin : g_byte
    always_ff @(posedge clk) begin
      if (reset) begin
        store[i] <= radcfg_pkg::pick_byte(radcfg_pkg::REGS_RESET, 2'(i));
      end else if (wr_en && wr_addr == 2'(i)) begin
        store[i] <= wr_data;
      end
    end
  end

  // Contents as one struct for the analog side
  assign regs = '{reg2: store[2], reg1: store[1], reg0: store[0]};

  // Registered read so the serial side sees a settled byte
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= radcfg_pkg::pick_byte(regs, rd_addr);
    end
  end

endmodule

`default_nettype wire

// ### test_radcfg_port.sv
`timescale 1ns/1ns
`default_nettype none

module test_radcfg_port;
  typedef struct packed {
    logic rw;
    logic [1:0] addr;
    logic [4:0] nbits;
    logic [23:0] data;
    logic [23:0] regs;
  } radcfg_row_s;

  logic clk;
  logic reset = 1'b1;
  logic slicer = 1'b0;
  logic sleep_req = 1'b0;
  logic clr = 1'b0;
  logic sel, sclk, hd, hoe, line, dout, doe, rxd, bclk, smode, active;
  logic bclk_q = 1'b0;
  logic [7:0] rx_shift = 8'h00;
  logic [23:0] rd;
  radcfg_pkg::radcfg_bytes_s regs;
  int err_count = 0;
  int check_count = 0;
  int rises = 0;
  int falls = 0;
  int clash = 0;
  radcfg_row_s rows [7] = '{
    '{1'b0, 2'h1, 5'h08, 24'h00_00a5, 24'h00_a500},
    '{1'b1, 2'h1, 5'h08, 24'h00_00a5, 24'h00_a500},
    '{1'b0, 2'h2, 5'h08, 24'h00_003c, 24'h3c_a500},
    '{1'b0, 2'h3, 5'h08, 24'h00_00ff, 24'h3c_a500},
    '{1'b1, 2'h3, 5'h08, 24'h00_0000, 24'h3c_a500},
    '{1'b0, 2'h2, 5'h18, 24'h11_2234, 24'h11_3422}, // Wrap 2 to 0
    '{1'b1, 2'h1, 5'h18, 24'h34_1122, 24'h11_3422}
  };

  //////////////////////////////////////////////////////////////////////////////
  // Line level: undriven shows the inverse of the port's data out
  assign line = doe ? dout : (hoe ? hd : !dout);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  radcfg_host host_u (.clk(clk), .line(line), .select(sel), .sclk(sclk), .sdata(hd),
                      .sdata_oe(hoe));

  radcfg_port dut_u (.clk(clk), .reset(reset), .config_select(sel),
    .config_serial_clock(sclk), .config_serial_data_in(line),
    .config_serial_data_out(dout), .config_serial_data_oe(doe), .slicer_data(slicer),
    .receive_data_out(rxd), .recovered_bit_clock(bclk), .sleep_request(sleep_req),
    .serial_control_mode(smode), .active_mode(active), .config_regs(regs));

  // Recovered bits taken at the bit clock falling edge, as a host would
  always @(posedge clk) begin
    bclk_q <= bclk;
    if (doe && hoe) clash <= clash + 1;
    if (clr) begin
      rises <= 0;
      falls <= 0;
    end else begin
      if (bclk && !bclk_q) rises <= rises + 1;
      if (!bclk && bclk_q && falls < 8) begin
        rx_shift <= {rx_shift[6:0], rxd};
        falls <= falls + 1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      slicer <= b[i];
      repeat (radcfg_pkg::BIT_CYCLES) @(posedge clk);
    end
  endtask

  task automatic clear_counts;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic end_of_test;
    $display("Counts: %0d checks, %0d mismatches", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_of_test;
  end

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    check(regs, 24'h00_0000);
    check(smode, 1'b0);
    check(active, 1'b1);
    check(doe, 1'b0);
    host_u.xfer(1'b0, 1'b0, 2'h1, 8, 24'h00_00ff, rd);
    check(regs, 24'h00_0000);
    check(smode, 1'b0);
    $display("Test unselected done");
    foreach (rows[i]) begin
      host_u.xfer(1'b1, rows[i].rw, rows[i].addr, rows[i].nbits, rows[i].data, rd);
      if (rows[i].rw) check(rd, rows[i].data);
      check(regs, rows[i].regs);
      check(doe, 1'b0);
    end
    check(smode, 1'b1);
    $display("Test register rows done");
    host_u.xfer(1'b1, 1'b0, 2'h1, 4, 24'h00_000f, rd);
    check(regs, 24'h11_3422);
    host_u.xfer(1'b1, 1'b0, 2'h1, 8, 24'h00_0077, rd);
    check(regs, 24'h11_7722);
    $display("Test partial byte done");
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk);
    check(active, 1'b0);
    host_u.xfer(1'b1, 1'b1, 2'h0, 8, 24'h00_0022, rd);
    check(active, 1'b1);
    check(smode, 1'b1);
    $display("Test wake done");
    // Recovery off: symbol must not start the clock
    clear_counts;
    send(radcfg_pkg::START_SYMBOL);
    send(8'h55);
    repeat (4) @(posedge clk);
    check(rxd, slicer);
    check(24'(rises), 24'h00_0000);
    host_u.xfer(1'b1, 1'b0, 2'h0, 8, 24'h00_0001, rd);
    clear_counts;
    send(8'h55);
    send(radcfg_pkg::START_SYMBOL);
    check(24'(rises), 24'h00_0000);
    send(8'h96);
    repeat (150) @(posedge clk);
    check(rx_shift, 8'h96);
    repeat (300) @(posedge clk);
    check(rises >= 10, 1'b1);
    host_u.xfer(1'b1, 1'b0, 2'h0, 8, 24'h00_0000, rd); // Stop after the packet
    clear_counts;
    repeat (300) @(posedge clk);
    check(24'(rises), 24'h00_0000);
    check(bclk, 1'b0);
    check(24'(clash), 24'h00_0000);
    $display("Test recovery done");
    end_of_test;
  end
endmodule

`default_nettype wire
